// >>> cpg_top.sv
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Single pulse: wait delay edges after arming, then pulse for width edges.
// - Start-triggered single pulse: one pulse per trigger, delay counted from trigger.
// - Finite train: count emitted pulses, stop generation at programmed count.
// - Retriggerable: each gate trigger outside a burst launches a fresh pulse or train.
// - Option picks delay on every trigger or first only; mode-dependent default.
// - Gate ignored during a retriggered burst; afterwards wait for next trigger.
// - Pause triggering refused while retriggering uses the gate.
// - At least two ticks pass between trigger and first counted delay edge.
// - Continuous train: separately programmed high and low phases after a delay.
// - Continuous train starts on arming or on a gate start trigger.
// - Gate as pause trigger suspends generation while active.
// - Continuous output period equals high plus low timebase periods.
// - Buffered implicit: each pulse after any start-triggered first pulse takes a new idle and active pair.
// - Buffered sample clocked: next pair loaded on each sample clock edge.
// - Buffered implicit ignores static settings and pulses equal supplied samples, except a start trigger adds a first pulse with static settings.
// - Sample clocked: static settings used until the first sample clock.
// - Implicit: one pulse per entry, idle then active, back to back.
// - Continuous buffered runs without a sample count until host stops.
// - On sample clock, current pulse completes before next entry applies.
// - After last sample clocked entry, keep generating with its settings.
// - Regeneration replays the loaded FIFO repeatedly and refuses further writes.
// - Empty FIFO when a pair is needed flags underflow.
module cpg_top
  import cpg_pkg::*;
#(
  parameter int DEPTH_LOG = CPG_DEPTH_LOG
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire logic [CPG_ADDR_W-1:0] av_address_in,
  input wire logic av_read_in,
  input wire logic av_write_in,
  input wire logic [31:0] av_writedata_in,
  input wire logic [3:0] av_byteenable_in,
  output logic [31:0] av_readdata_out,
  output logic av_waitrequest_out,
  // Timing inputs
  input wire logic source_in,
  input wire logic gate_in,
  input wire logic sample_clk_in,
  // Counter output
  output logic pulse_out
);

  localparam logic [DEPTH_LOG:0] DEPTH = {1'b1, {DEPTH_LOG{1'b0}}};
  localparam logic [DEPTH_LOG:0] LEVEL_ONE = {{DEPTH_LOG{1'b0}}, 1'b1};
  localparam logic [DEPTH_LOG-1:0] PTR_ONE = {{(DEPTH_LOG-1){1'b0}}, 1'b1};

  // ==========================================================
  // Functions
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic edge_hit(input logic prev, input logic now, input logic fall);
    return fall ? (prev & ~now) : (~prev & now);
  endfunction

  function automatic logic phase_end(input logic [31:0] cnt, input logic [31:0] width);
    return ({1'b0, cnt} + 33'h1) >= {1'b0, width};
  endfunction

  // ==========================================================
  // Declarations
  logic [31:0] ctrl_r, delay_r, high_r, low_r, count_r, idle_stage_r;
  logic wait_r;
  logic wr_go, rd_go, fifo_clr;
  logic [31:0] status;
  logic src_d_r, gate_d_r, sclk_d_r, arm_d_r;
  logic tick, trig, sclk_edge;
  cpg_mode_type mode;
  logic armed, retrig, start_trig, pause_en, pause_now, dly_every;
  cpg_state_type state_r;
  logic [31:0] ph_cnt_r, pulses_r, loads_r, cur_idle_r, cur_act_r;
  logic [1:0] settle_r;
  logic first_r, samp_pend_r, under_r, under_set, pop_r, samp_take;
  logic [DEPTH_LOG-1:0] wr_ptr_r, rd_ptr_r, start_ptr_r;
  logic [DEPTH_LOG:0] level_r;
  logic push, push_d_r, fifo_ready, fifo_full, regen_lock;
  logic [CPG_ENTRY_W-1:0] mem_q;
  logic [31:0] static_idle;
  logic buf_finished;

  // ==========================================================
  // Bus decode
  assign wr_go = av_write_in && !wait_r;
  assign rd_go = av_read_in && wait_r;
  assign fifo_clr = wr_go && (av_address_in == OFS_CTRL) && av_byteenable_in[1]
                    && av_writedata_in[CTRL_FIFO_CLR];

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= !((av_read_in || av_write_in) && wait_r);
    end
  end

  assign av_waitrequest_out = wait_r;

  always_comb begin
    status = 32'h0;
    status[STAT_RUNNING] = (state_r != ST_STOP) && (state_r != ST_DONE);
    status[STAT_DONE] = (state_r == ST_DONE);
    status[STAT_UNDERFLOW] = under_r;
    status[STAT_OUT] = pulse_out;
    status[STAT_FULL] = fifo_full;
    status[STAT_LEVEL_LSB +: DEPTH_LOG+1] = level_r;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      av_readdata_out <= 32'h0;
    end else if (rd_go) begin
      case (av_address_in)
        OFS_CTRL: av_readdata_out <= ctrl_r;
        OFS_DELAY: av_readdata_out <= delay_r;
        OFS_HIGH: av_readdata_out <= high_r;
        OFS_LOW: av_readdata_out <= low_r;
        OFS_COUNT: av_readdata_out <= count_r;
        OFS_STATUS: av_readdata_out <= status;
        OFS_FIFO_IDLE: av_readdata_out <= idle_stage_r;
        default: av_readdata_out <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctrl_r <= CTRL_RST;
      delay_r <= CNT_RST;
      high_r <= CNT_RST;
      low_r <= CNT_RST;
      count_r <= CNT_RST;
      idle_stage_r <= CNT_RST;
    end else if (wr_go) begin
      case (av_address_in)
        OFS_CTRL: ctrl_r <= be_merge(ctrl_r, av_writedata_in, av_byteenable_in) & CTRL_KEEP_MASK;
        OFS_DELAY: delay_r <= be_merge(delay_r, av_writedata_in, av_byteenable_in);
        OFS_HIGH: high_r <= be_merge(high_r, av_writedata_in, av_byteenable_in);
        OFS_LOW: low_r <= be_merge(low_r, av_writedata_in, av_byteenable_in);
        OFS_COUNT: count_r <= be_merge(count_r, av_writedata_in, av_byteenable_in);
        OFS_FIFO_IDLE: idle_stage_r <= be_merge(idle_stage_r, av_writedata_in, av_byteenable_in);
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Mode decode and input edges
  assign mode = cpg_mode_type'(ctrl_r[CTRL_MODE_LSB +: 3]);
  assign armed = ctrl_r[CTRL_ARM];
  assign retrig = ctrl_r[CTRL_RETRIG] && (mode == MODE_SINGLE || mode == MODE_FINITE);
  assign start_trig = ctrl_r[CTRL_START_TRIG] || retrig;
  assign pause_en = ctrl_r[CTRL_PAUSE_EN] && !start_trig;
  assign pause_now = pause_en && (gate_in ^ ctrl_r[CTRL_PAUSE_LOW]);
  assign dly_every = (mode == MODE_SINGLE) ? ctrl_r[CTRL_DLY_SINGLE] : ctrl_r[CTRL_DLY_TRAIN];

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      src_d_r <= 1'b0;
      gate_d_r <= 1'b0;
      sclk_d_r <= 1'b0;
      arm_d_r <= 1'b0;
    end else begin
      src_d_r <= source_in;
      gate_d_r <= gate_in;
      sclk_d_r <= sample_clk_in;
      arm_d_r <= armed;
    end
  end

  assign tick = edge_hit(src_d_r, source_in, ctrl_r[CTRL_SRC_FALL]);
  assign trig = edge_hit(gate_d_r, gate_in, ctrl_r[CTRL_GATE_FALL]);
  assign sclk_edge = edge_hit(sclk_d_r, sample_clk_in, ctrl_r[CTRL_SCLK_FALL]);

  // ==========================================================
  // Pulse FIFO
  assign fifo_full = (level_r == DEPTH);
  assign regen_lock = ctrl_r[CTRL_REGEN] && armed;
  assign push = wr_go && (av_address_in == OFS_FIFO_ACTIVE) && !fifo_full && !regen_lock;
  assign fifo_ready = (level_r != 0) && !((level_r == LEVEL_ONE) && push_d_r);

  always_ff @(posedge clk_in) begin
    if (!rstn_in || fifo_clr) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
      push_d_r <= 1'b0;
    end else begin
      push_d_r <= push;
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PTR_ONE;
      end
      if (pop_r && ctrl_r[CTRL_REGEN]) begin
        rd_ptr_r <= (rd_ptr_r + PTR_ONE == wr_ptr_r) ? start_ptr_r : rd_ptr_r + PTR_ONE;
      end else if (pop_r) begin
        rd_ptr_r <= rd_ptr_r + PTR_ONE;
      end
      if (push && !(pop_r && !ctrl_r[CTRL_REGEN])) begin
        level_r <= level_r + LEVEL_ONE;
      end else if (!push && pop_r && !ctrl_r[CTRL_REGEN]) begin
        level_r <= level_r - LEVEL_ONE;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      start_ptr_r <= '0;
    end else if (armed && !arm_d_r) begin
      start_ptr_r <= rd_ptr_r;
    end
  end

  cpg_mem #(
    .W(CPG_ENTRY_W),
    .AW(DEPTH_LOG)
  ) u_mem (
    .clk_in(clk_in),
    .wr_en_in(push),
    .wr_addr_in(wr_ptr_r),
    .wr_data_in({idle_stage_r, av_writedata_in}),
    .rd_addr_in(rd_ptr_r),
    .rd_data_out(mem_q)
  );

  // ==========================================================
  // Sample clock pending flag
  assign samp_take = (state_r == ST_HIGH) && tick && !pause_now && phase_end(ph_cnt_r, cur_act_r)
                     && (mode == MODE_BUF_SAMP);

  always_ff @(posedge clk_in) begin
    if (!rstn_in || !armed) begin
      samp_pend_r <= 1'b0;
    end else if (sclk_edge && (mode == MODE_BUF_SAMP)) begin
      samp_pend_r <= 1'b1;
    end else if (samp_take) begin
      samp_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // Underflow flag, set wins over clear
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      under_r <= 1'b0;
    end else if (under_set) begin
      under_r <= 1'b1;
    end else if (wr_go && (av_address_in == OFS_STATUS) && av_byteenable_in[0]
                 && av_writedata_in[STAT_UNDERFLOW]) begin
      under_r <= 1'b0;
    end
  end

  // ==========================================================
  // Generator sequencer
  assign static_idle = (first_r || dly_every) ? delay_r : low_r;
  assign buf_finished = ctrl_r[CTRL_BUF_FINITE] && (loads_r >= count_r);
  assign under_set = !ctrl_r[CTRL_REGEN] && !fifo_ready && (
                       ((state_r == ST_STOP) && armed && !arm_d_r && !start_trig
                        && (mode == MODE_BUF_IMPL))
                     || ((state_r == ST_HIGH) && tick && !pause_now
                         && phase_end(ph_cnt_r, cur_act_r)
                         && (((mode == MODE_BUF_IMPL) && !buf_finished)
                             || (samp_pend_r && (mode == MODE_BUF_SAMP) && !buf_finished))));

  always_ff @(posedge clk_in) begin
    if (!rstn_in || !armed) begin
      state_r <= ST_STOP;
      ph_cnt_r <= 32'h0;
      pulses_r <= 32'h0;
      loads_r <= 32'h0;
      cur_idle_r <= 32'h0;
      cur_act_r <= 32'h0;
      settle_r <= 2'h0;
      first_r <= 1'b1;
      pop_r <= 1'b0;
    end else begin
      pop_r <= 1'b0;
      case (state_r)
        ST_STOP: begin
          if (!arm_d_r) begin
            ph_cnt_r <= 32'h0;
            if (start_trig) begin
              state_r <= ST_WAIT_TRIG;
            end else if (mode == MODE_BUF_IMPL) begin
              if (fifo_ready) begin
                cur_idle_r <= mem_q[63:32];
                cur_act_r <= mem_q[31:0];
                loads_r <= 32'h1;
                pop_r <= 1'b1;
                state_r <= ST_LOW;
              end else begin
                state_r <= ST_DONE;
              end
            end else begin
              cur_idle_r <= static_idle;
              cur_act_r <= high_r;
              state_r <= ST_LOW;
            end
          end
        end
        ST_WAIT_TRIG: begin
          if (trig) begin
            settle_r <= 2'h0;
            pulses_r <= 32'h0;
            state_r <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (tick) begin
            if (settle_r == TRIG_SETTLE_TICKS - 2'h1) begin
              cur_idle_r <= static_idle;
              cur_act_r <= high_r;
              ph_cnt_r <= 32'h0;
              state_r <= ST_LOW;
            end else begin
              settle_r <= settle_r + 2'h1;
            end
          end
        end
        ST_LOW: begin
          if (tick && !pause_now) begin
            if (phase_end(ph_cnt_r, cur_idle_r)) begin
              ph_cnt_r <= 32'h0;
              state_r <= ST_HIGH;
            end else begin
              ph_cnt_r <= ph_cnt_r + 32'h1;
            end
          end
        end
        ST_HIGH: begin
          if (tick && !pause_now) begin
            if (phase_end(ph_cnt_r, cur_act_r)) begin
              ph_cnt_r <= 32'h0;
              pulses_r <= pulses_r + 32'h1;
              first_r <= 1'b0;
              case (mode)
                MODE_SINGLE: begin
                  state_r <= retrig ? ST_WAIT_TRIG : ST_DONE;
                end
                MODE_FINITE: begin
                  if (pulses_r + 32'h1 >= count_r) begin
                    state_r <= retrig ? ST_WAIT_TRIG : ST_DONE;
                  end else begin
                    cur_idle_r <= low_r;
                    state_r <= ST_LOW;
                  end
                end
                MODE_CONT: begin
                  cur_idle_r <= low_r;
                  state_r <= ST_LOW;
                end
                MODE_BUF_IMPL: begin
                  if (buf_finished) begin
                    state_r <= ST_DONE;
                  end else if (fifo_ready) begin
                    cur_idle_r <= mem_q[63:32];
                    cur_act_r <= mem_q[31:0];
                    loads_r <= loads_r + 32'h1;
                    pop_r <= 1'b1;
                    state_r <= ST_LOW;
                  end else begin
                    state_r <= ST_DONE;
                  end
                end
                MODE_BUF_SAMP: begin
                  if (samp_pend_r && !buf_finished && fifo_ready) begin
                    cur_idle_r <= mem_q[63:32];
                    cur_act_r <= mem_q[31:0];
                    loads_r <= loads_r + 32'h1;
                    pop_r <= 1'b1;
                  end else if (loads_r == 32'h0) begin
                    cur_idle_r <= low_r;
                  end
                  state_r <= ST_LOW;
                end
                default: begin
                  state_r <= ST_DONE;
                end
              endcase
            end else begin
              ph_cnt_r <= ph_cnt_r + 32'h1;
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_STOP;
        end
      endcase
    end
  end

  // ==========================================================
  // Output register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= armed && (state_r == ST_HIGH) && !pause_now;
    end
  end

endmodule // cpg_top
`default_nettype wire

// >>> cpg_pkg.sv
`default_nettype none
package cpg_pkg;

  // ==========================================================
  // Sizes
  localparam int CPG_DEPTH_LOG = 4;
  localparam int CPG_CNT_W = 32;
  localparam int CPG_ENTRY_W = 64;
  localparam int CPG_ADDR_W = 5;

  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_DELAY = 5'h04;
  localparam logic [4:0] OFS_HIGH = 5'h08;
  localparam logic [4:0] OFS_LOW = 5'h0c;
  localparam logic [4:0] OFS_COUNT = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_FIFO_IDLE = 5'h18;
  localparam logic [4:0] OFS_FIFO_ACTIVE = 5'h1c;

  // ==========================================================
  // Control fields
  localparam int CTRL_ARM = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_START_TRIG = 4;
  localparam int CTRL_RETRIG = 5;
  localparam int CTRL_PAUSE_EN = 6;
  localparam int CTRL_DLY_SINGLE = 7;
  localparam int CTRL_DLY_TRAIN = 8;
  localparam int CTRL_SRC_FALL = 9;
  localparam int CTRL_GATE_FALL = 10;
  localparam int CTRL_PAUSE_LOW = 11;
  localparam int CTRL_BUF_FINITE = 12;
  localparam int CTRL_REGEN = 13;
  localparam int CTRL_SCLK_FALL = 14;
  localparam int CTRL_FIFO_CLR = 15;
  localparam logic [31:0] CTRL_RST = 32'h0000_0080;
  localparam logic [31:0] CTRL_KEEP_MASK = 32'h0000_7fff;

  // ==========================================================
  // Status fields
  localparam int STAT_RUNNING = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_UNDERFLOW = 2;
  localparam int STAT_OUT = 3;
  localparam int STAT_FULL = 4;
  localparam int STAT_LEVEL_LSB = 8;

  // ==========================================================
  // Reset values and timing
  localparam logic [31:0] CNT_RST = 32'h0000_0001;
  localparam logic [1:0] TRIG_SETTLE_TICKS = 2'h2;

  // ==========================================================
  // Modes and states
  typedef enum logic [2:0] {
    MODE_SINGLE = 3'h0,
    MODE_FINITE = 3'h1,
    MODE_CONT = 3'h2,
    MODE_BUF_IMPL = 3'h3,
    MODE_BUF_SAMP = 3'h4
  } cpg_mode_type;

  typedef enum logic [5:0] {
    ST_STOP = 6'h01,
    ST_WAIT_TRIG = 6'h02,
    ST_SETTLE = 6'h04,
    ST_LOW = 6'h08,
    ST_HIGH = 6'h10,
    ST_DONE = 6'h20
  } cpg_state_type;

endpackage
`default_nettype wire

// >>> cpg_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cpg_mem #(
  parameter int W = 64,
  parameter int AW = 4
) (
  // Clock
  input wire logic clk_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [W-1:0] wr_data_in,
  // Read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [W-1:0] rd_data_out
);

  logic [W-1:0] mem_r [0:(1<<AW)-1];

  // ==========================================================
  // Storage
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rd_data_out <= mem_r[rd_addr_in];
  end

endmodule // cpg_mem
`default_nettype wire

// >>> cpg_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cpg_top_monitor
  import cpg_pkg::*;
#(
  parameter int DEPTH_LOG = CPG_DEPTH_LOG
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register bus
  input wire logic [CPG_ADDR_W-1:0] av_address_in,
  input wire logic av_read_in,
  input wire logic av_write_in,
  input wire logic [31:0] av_writedata_in,
  input wire logic [3:0] av_byteenable_in,
  input wire logic [31:0] av_readdata_out,
  input wire logic av_waitrequest_out,
  // Timing and output
  input wire logic source_in,
  input wire logic gate_in,
  input wire logic sample_clk_in,
  input wire logic pulse_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========================================================
  // Recent input activity that may move the output
  logic [5:0] src_act_r;
  logic [5:0] ctl_act_r;
  logic src_q_r;
  logic gate_q_r;
  always_ff @(posedge clk_in) begin
    src_q_r <= source_in;
    gate_q_r <= gate_in;
    src_act_r <= {src_act_r[4:0], source_in != src_q_r};
    ctl_act_r <= {ctl_act_r[4:0], (gate_in != gate_q_r) || av_write_in};
  end
  // ==========================================================
  // Bus handshake
  a_wait_answer: assert property ($rose(av_read_in || av_write_in) |=> !av_waitrequest_out)
    else $error("waitrequest not low one cycle after request");
  a_wait_single: assert property (!av_waitrequest_out |=> av_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_wait_needs_req: assert property (!av_waitrequest_out |->
    (av_read_in || av_write_in) && $past(av_read_in || av_write_in))
    else $error("waitrequest low without a request");
  a_rdata_on_read: assert property ($changed(av_readdata_out) |->
    !av_waitrequest_out && av_read_in)
    else $error("read data changed outside a read");
  a_reset_quiet: assert property ($rose(rstn_in) |->
    !pulse_out && av_waitrequest_out && av_readdata_out == 32'h0)
    else $error("outputs not at reset levels");
  // ==========================================================
  // Output timing
  a_out_on_tick: assert property ($changed(pulse_out) |->
    (src_act_r != 6'h0) || (ctl_act_r != 6'h0))
    else $error("output moved without a timebase edge");
  a_high_two_cycles: assert property ($rose(pulse_out) |=>
    pulse_out || (ctl_act_r != 6'h0))
    else $error("active phase shorter than one tick");
  a_low_two_cycles: assert property ($fell(pulse_out) |=>
    !pulse_out || (ctl_act_r != 6'h0))
    else $error("idle phase shorter than one tick");
  c_pulse: cover property ($rose(pulse_out));
  c_read: cover property (!av_waitrequest_out && av_read_in);
  c_write: cover property (!av_waitrequest_out && av_write_in);
endmodule // cpg_top_monitor

bind cpg_top cpg_top_monitor #(.DEPTH_LOG(DEPTH_LOG)) u_cpg_top_monitor (
  .clk_in(clk_in), .rstn_in(rstn_in), .av_address_in(av_address_in),
  .av_read_in(av_read_in), .av_write_in(av_write_in), .av_writedata_in(av_writedata_in),
  .av_byteenable_in(av_byteenable_in), .av_readdata_out(av_readdata_out),
  .av_waitrequest_out(av_waitrequest_out), .source_in(source_in), .gate_in(gate_in),
  .sample_clk_in(sample_clk_in), .pulse_out(pulse_out));
`default_nettype wire

// >>> cpg_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpg_far_model (
  // Control from bench
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic trig_in,
  input wire logic pause_in,
  // Timing lines to the device
  output logic source_out = 1'b0,
  output logic gate_out = 1'b0,
  output logic sample_clk_out = 1'b0
);
  logic [1:0] div_r = 2'h0;
  logic [2:0] trig_r = 3'h0;
  // ==========================================================
  // Timebase stands low when stopped, else a level every two clocks
  always @(posedge clk_in) begin
    div_r <= run_in ? div_r + 2'h1 : 2'h0;
    if (!run_in) begin
      source_out <= 1'b0;
    end else if (div_r[0]) begin
      source_out <= ~source_out;
    end
  end
  // ==========================================================
  // Gate carries a four clock trigger pulse or a held pause level
  // Sample clock follows the trigger pulse
  always @(posedge clk_in) begin
    trig_r <= trig_in ? 3'h4 : (trig_r != 3'h0 ? trig_r - 3'h1 : 3'h0);
    gate_out <= pause_in || trig_r != 3'h0;
    sample_clk_out <= trig_r != 3'h0;
  end
endmodule // cpg_far_model
`default_nettype wire

// >>> cpg_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, (ex), (got)); end end
module cpg_top_tb_top
  import cpg_pkg::*;
;
  logic clk_in, rstn_in, av_read, av_write, av_wait, source, gate, sclk, pulse;
  logic run, trig, pause;
  logic [CPG_ADDR_W-1:0] av_address;
  logic [31:0] av_wdata, av_rdata, q;
  int err_total, checks, rise_n, high_n, dly_n, t1, t2, cyc;
  cpg_top u_cpg_top (.clk_in(clk_in), .rstn_in(rstn_in), .av_address_in(av_address),
    .av_read_in(av_read), .av_write_in(av_write), .av_writedata_in(av_wdata),
    .av_byteenable_in(4'hf), .av_readdata_out(av_rdata), .av_waitrequest_out(av_wait),
    .source_in(source), .gate_in(gate), .sample_clk_in(sclk), .pulse_out(pulse));
  cpg_far_model u_cpg_far_model (.clk_in(clk_in), .run_in(run), .trig_in(trig),
    .pause_in(pause), .source_out(source), .gate_out(gate), .sample_clk_out(sclk));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ==========================================================
  // Shared tasks
  task automatic end_sim();
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    av_address <= a;
    av_wdata <= d;
    av_write <= w;
    av_read <= !w;
    do begin
      @(posedge clk_in);
      n++;
    end while (av_wait !== 1'b0 && n < 50);
    q = av_rdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
    if (av_wait !== 1'b0) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic setp(input logic [31:0] d, input logic [31:0] h, input logic [31:0] l,
                      input logic [31:0] c);
    wr(OFS_DELAY, d);
    wr(OFS_HIGH, h);
    wr(OFS_LOW, l);
    wr(OFS_COUNT, c);
  endtask
  task automatic arm(input logic [31:0] c);
    wr(OFS_CTRL, c);
    run <= 1'b1;
    {rise_n, high_n, dly_n, t1, t2, cyc} = '0;
  endtask
  task automatic stop();
    wr(OFS_CTRL, CTRL_RST);
    run <= 1'b0;
  endtask
  task automatic fire();
    trig <= 1'b1;
    @(posedge clk_in);
    trig <= 1'b0;
  endtask
  task automatic watch(input int c);
    logic p, s;
    repeat (c) begin
      p = pulse;
      s = source;
      @(posedge clk_in);
      cyc++;
      if (source && !s && rise_n == 0) dly_n++;
      if (pulse && !p) begin
        rise_n++;
        if (rise_n == 1) t1 = cyc;
        if (rise_n == 2) t2 = cyc;
      end
      if (pulse) high_n++;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0);
      `CHK("reg reset", (i == 0 ? CTRL_RST : CNT_RST), q)
    end
  endtask
  task automatic t_single();
    setp(32'h4, 32'h3, 32'h1, 32'h1);
    arm(32'h81);
    watch(100);
    `CHK("single delay", 4, dly_n)
    `CHK("single width", 12, high_n)
    `CHK("single count", 1, rise_n)
    stop();
  endtask
  task automatic t_cont();
    setp(32'h3, 32'h2, 32'h3, 32'h1);
    arm(32'h85);
    watch(120);
    `CHK("cont delay", 3, dly_n)
    `CHK("cont period", 20, t2 - t1)
    stop();
  endtask
  task automatic t_finite();
    setp(32'h1, 32'h1, 32'h1, 32'h3);
    arm(32'h83);
    watch(150);
    `CHK("finite count", 3, rise_n)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("finite done", 1'b1, q[STAT_DONE])
    stop();
  endtask
  task automatic t_retrig();
    setp(32'h2, 32'h3, 32'h1, 32'h1);
    arm(32'hb1);
    watch(20);
    `CHK("no trigger", 0, rise_n)
    dly_n = 0;
    fire();
    watch(26);
    fire();
    watch(30);
    fire();
    watch(60);
    `CHK("retrig count", 2, rise_n)
    `CHK("trig delay", 5, dly_n)
    stop();
  endtask
  task automatic t_pause();
    setp(32'h1, 32'h1, 32'h1, 32'h1);
    pause <= 1'b1;
    arm(32'hc5);
    watch(80);
    `CHK("paused high", 0, high_n)
    pause <= 1'b0;
    watch(80);
    `CHK("resumed", 1'b1, (rise_n > 0))
    stop();
  endtask
  task automatic t_buf();
    int idl[3] = '{2, 3, 2};
    int act[3] = '{2, 4, 2};
    wr(OFS_CTRL, 32'h8080);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_FIFO_IDLE, 32'(idl[i]));
      wr(OFS_FIFO_ACTIVE, 32'(act[i]));
    end
    setp(32'h9, 32'h9, 32'h9, 32'h3);
    arm(32'h1087);
    watch(200);
    `CHK("buf count", 3, rise_n)
    `CHK("buf width", 32, high_n)
    `CHK("buf spacing", 20, t2 - t1)
    stop();
    wr(OFS_CTRL, 32'h8080);
    arm(32'h87);
    watch(40);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("underflow", 1'b1, q[STAT_UNDERFLOW])
    stop();
  endtask
  task automatic t_samp();
    wr(OFS_CTRL, 32'h8080);
    wr(OFS_FIFO_IDLE, 32'h1);
    wr(OFS_FIFO_ACTIVE, 32'h6);
    setp(32'h3, 32'h2, 32'h2, 32'h1);
    arm(32'h89);
    watch(40);
    `CHK("samp static", 16, high_n)
    fire();
    watch(43);
    `CHK("samp entry", 48, high_n)
    stop();
  endtask
  initial begin
    {err_total, checks} = '0;
    {rstn_in, av_read, av_write, run, trig, pause} = '0;
    av_address = '0;
    av_wdata = '0;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_single();
    t_cont();
    t_finite();
    t_retrig();
    t_pause();
    t_buf();
    t_samp();
    end_sim();
  end
endmodule // cpg_top_tb_top
`default_nettype wire
